// ### shared/tsn_pkg.sv
// constants and types shared by the terminal status notify block
// Behaviour
// - run bit fifteen high only in run
// - no controller access while run bit low, after the one write that clears it
// - periodically rewrite one into run bit
// - screen change sets bit twelve, clears after notify
// - numeral entry sets bit eleven, clears after notify
// - write status word whenever status changes
package tsn_pkg;

  // clock rate and refresh interval of the run bit
  localparam int unsigned TSN_CLK_HZ = 10_000_000;
  localparam int unsigned TSN_REFRESH_MS = 1000;
  localparam int unsigned TSN_REFRESH_CYC = TSN_REFRESH_MS * (TSN_CLK_HZ / 1000);
  localparam int unsigned TSN_TMR_W = 24;

  // status word layout
  localparam int unsigned TSN_WORD_W = 16;
  localparam int unsigned TSN_BIT_RUN = 15;
  localparam int unsigned TSN_BIT_SCR = 12;
  localparam int unsigned TSN_BIT_NUM = 11;
  localparam logic [15:0] TSN_WORD_RST = 16'h0000;

  // register byte offsets on the avalon slave
  localparam logic [3:0] TSN_OFF_WORD = 4'h0;
  localparam logic [3:0] TSN_OFF_CTRL = 4'h4;
  localparam logic [3:0] TSN_OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] TSN_OFF_IRQ_MASK = 4'hC;

  // control and interrupt fields
  localparam int unsigned TSN_CTRL_EN = 0;
  localparam logic TSN_CTRL_RST = 1'h1;
  localparam int unsigned TSN_WORD_BUSY = 16;
  localparam int unsigned TSN_IRQ_W = 4;
  localparam int unsigned TSN_IRQ_SCR = 0;
  localparam int unsigned TSN_IRQ_NUM = 1;
  localparam int unsigned TSN_IRQ_DONE = 2;
  localparam int unsigned TSN_IRQ_STOP = 3;
  localparam logic [3:0] TSN_IRQ_RST = 4'h0;

  typedef enum logic {TSN_ST_IDLE, TSN_ST_WRITE} tsn_state_t;

endpackage

// ### src/tsn_refresh_timer.sv
// interval timer that paces the run bit refresh
`timescale 1ns/100ps
`default_nettype none
module tsn_refresh_timer
  import tsn_pkg::*;
#(
  parameter int unsigned PERIOD = TSN_REFRESH_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run,
  output logic tick
);

  localparam logic [TSN_TMR_W-1:0] LAST = TSN_TMR_W'(PERIOD - 1);

  logic [TSN_TMR_W-1:0] count_reg;

  // restart from zero whenever run mode is left so the first tick is a full period away
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !run)
    begin
      count_reg <= '0;
    end
    else if (count_reg == LAST)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_reg + TSN_TMR_W'(1);
    end
  end

  assign tick = run && (count_reg == LAST);

endmodule
`default_nettype wire

// ### src/tsn_status_notify.sv
// status notify word writer with avalon register slave
`timescale 1ns/100ps
`default_nettype none
module tsn_status_notify
  import tsn_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = TSN_REFRESH_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic run_mode,
  input wire logic sys_menu_shown,
  input wire logic screen_switched,
  input wire logic numeral_entered,
  output logic notify_wr_req,
  output logic [15:0] notify_wr_data,
  input wire logic notify_wr_ack,
  output logic irq
);

  // assemble the word that goes to controller memory
  function automatic logic [15:0] build_word(input logic run, input logic scr, input logic num);
    logic [15:0] w;
    w = TSN_WORD_RST;
    w[TSN_BIT_RUN] = run;
    w[TSN_BIT_SCR] = scr;
    w[TSN_BIT_NUM] = num;
    return w;
  endfunction

  tsn_state_t state_reg;
  logic run_reg;
  logic scr_pend_reg;
  logic num_pend_reg;
  logic refresh_pend_reg;
  logic [15:0] sent_word_reg;
  logic [15:0] wr_data_reg;
  logic ctrl_en_reg;
  logic [TSN_IRQ_W-1:0] irq_stat_reg;
  logic [TSN_IRQ_W-1:0] irq_mask_reg;
  logic [TSN_IRQ_W-1:0] irq_next;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] cur_word;
  logic access_ok;
  logic start_wr;
  logic done_wr;
  logic tick;
  logic bus_req;
  logic bus_wr;
  logic [TSN_IRQ_W-1:0] w1c;

  // run bit is high only in run mode with no system menu up
  // run bit level
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      run_reg <= 1'b0;
    end
    else
    begin
      run_reg <= run_mode && !sys_menu_shown;
    end
  end

  tsn_refresh_timer #(
    .PERIOD(REFRESH_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run(run_reg),
    .tick(tick)
  );

  assign cur_word = build_word(run_reg, scr_pend_reg, num_pend_reg);
  assign done_wr = (state_reg == TSN_ST_WRITE) && notify_wr_ack;

  // access allowed while running, plus one last write that drops the run bit
  // no access stopped
  assign access_ok = ctrl_en_reg && (run_reg || sent_word_reg[TSN_BIT_RUN]);

  assign start_wr = (state_reg == TSN_ST_IDLE) && access_ok
                    && ((cur_word != sent_word_reg) || refresh_pend_reg);

  // periodic rewrite restores a run bit the controller cleared
  // refresh run bit
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !run_reg)
    begin
      refresh_pend_reg <= 1'b0;
    end
    else if (tick)
    begin
      refresh_pend_reg <= 1'b1;
    end
    else if (start_wr)
    begin
      refresh_pend_reg <= 1'b0;
    end
  end

  // screen strobe; a new event in the ack cycle wins over the clear
  // screen strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      scr_pend_reg <= 1'b0;
    end
    else if (screen_switched && run_reg)
    begin
      scr_pend_reg <= 1'b1;
    end
    else if (done_wr && wr_data_reg[TSN_BIT_SCR])
    begin
      scr_pend_reg <= 1'b0;
    end
  end

  // numeral strobe, same set-over-clear handling
  // numeral strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      num_pend_reg <= 1'b0;
    end
    else if (numeral_entered && run_reg)
    begin
      num_pend_reg <= 1'b1;
    end
    else if (done_wr && wr_data_reg[TSN_BIT_NUM])
    begin
      num_pend_reg <= 1'b0;
    end
  end

  // write sequencer; the word is frozen for the whole write, later changes wait
  // merge pending changes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg <= TSN_ST_IDLE;
      wr_data_reg <= TSN_WORD_RST;
      sent_word_reg <= TSN_WORD_RST;
    end
    else
    begin
      case (state_reg)
        TSN_ST_IDLE:
        begin
          if (start_wr)
          begin
            wr_data_reg <= cur_word;
            state_reg <= TSN_ST_WRITE;
          end
        end
        TSN_ST_WRITE:
        begin
          if (notify_wr_ack)
          begin
            sent_word_reg <= wr_data_reg;
            state_reg <= TSN_ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= TSN_ST_IDLE;
        end
      endcase
    end
  end

  assign notify_wr_req = (state_reg == TSN_ST_WRITE);
  assign notify_wr_data = wr_data_reg;

  // avalon slave: one wait cycle, then the request completes
  assign bus_req = avs_read || avs_write;
  assign bus_wr = avs_write && ack_reg && avs_byteenable[0];
  assign avs_waitrequest = bus_req && !ack_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // read data settles during the wait cycle; unmapped offsets read zero
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rdata_reg <= '0;
    end
    else if (avs_read && !ack_reg)
    begin
      rdata_reg <= '0;
      case (avs_address)
        TSN_OFF_WORD:
        begin
          rdata_reg[TSN_WORD_W-1:0] <= cur_word;
          rdata_reg[TSN_WORD_BUSY] <= notify_wr_req;
        end
        TSN_OFF_CTRL: rdata_reg[TSN_CTRL_EN] <= ctrl_en_reg;
        TSN_OFF_IRQ_STAT: rdata_reg[TSN_IRQ_W-1:0] <= irq_stat_reg;
        TSN_OFF_IRQ_MASK: rdata_reg[TSN_IRQ_W-1:0] <= irq_mask_reg;
        default: rdata_reg <= '0;
      endcase
    end
  end

  assign avs_readdata = rdata_reg;

  // software control: notification enable and interrupt mask
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ctrl_en_reg <= TSN_CTRL_RST;
      irq_mask_reg <= TSN_IRQ_RST;
    end
    else if (bus_wr && (avs_address == TSN_OFF_CTRL))
    begin
      ctrl_en_reg <= avs_writedata[TSN_CTRL_EN];
    end
    else if (bus_wr && (avs_address == TSN_OFF_IRQ_MASK))
    begin
      irq_mask_reg <= avs_writedata[TSN_IRQ_W-1:0];
    end
  end

  // sticky events, cleared by writing one; a same-cycle event keeps its bit
  assign w1c = (bus_wr && (avs_address == TSN_OFF_IRQ_STAT))
               ? avs_writedata[TSN_IRQ_W-1:0] : TSN_IRQ_RST;

  always_comb
  begin
    irq_next = irq_stat_reg & ~w1c;
    if (screen_switched && run_reg)
    begin
      irq_next[TSN_IRQ_SCR] = 1'b1;
    end
    if (numeral_entered && run_reg)
    begin
      irq_next[TSN_IRQ_NUM] = 1'b1;
    end
    if (done_wr)
    begin
      irq_next[TSN_IRQ_DONE] = 1'b1;
    end
    if (run_reg && !(run_mode && !sys_menu_shown))
    begin
      irq_next[TSN_IRQ_STOP] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      irq_stat_reg <= TSN_IRQ_RST;
    end
    else
    begin
      irq_stat_reg <= irq_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // word latched at write start carries the live run level
  a_run_bit_word: assert property (
    start_wr |=> notify_wr_data[TSN_BIT_RUN] == $past(run_reg))
    else $error("run bit in written word differs from run state");

  // a write only goes out while running or to drop the run bit
  a_no_stopped_access: assert property (
    $rose(notify_wr_req) |-> (notify_wr_data[TSN_BIT_RUN] || $past(sent_word_reg[TSN_BIT_RUN])))
    else $error("controller access while run bit low");

  // a refresh tick in run mode leads to a write within a short time
  a_refresh_write: assert property (
    (tick && ctrl_en_reg && !notify_wr_req && !notify_wr_ack && run_mode && !sys_menu_shown)
      |-> ##[1:2] (notify_wr_req && notify_wr_data[TSN_BIT_RUN]))
    else $error("refresh tick produced no run bit write");

  // screen strobe set by an event and cleared after a write that carried it
  a_scr_strobe: assert property (
    (done_wr && wr_data_reg[TSN_BIT_SCR] && !screen_switched) |=> !scr_pend_reg)
    else $error("screen strobe not cleared after notification");

  a_scr_set: assert property (
    (screen_switched && run_reg) |=> scr_pend_reg ##0 cur_word[TSN_BIT_SCR])
    else $error("screen strobe not set by screen change");

  // numeral strobe: an entry while idle is written as one in a write starting one or two cycles later
  a_num_strobe: assert property (
    (numeral_entered && run_reg && !notify_wr_req && ctrl_en_reg && !start_wr)
      |=> ##[0:1] (notify_wr_req && notify_wr_data[TSN_BIT_NUM]))
    else $error("numeral entry not written to controller");

  // any change of the live word while idle and access is allowed starts a write next cycle
  a_change_written: assert property (
    (state_reg == TSN_ST_IDLE && access_ok && cur_word != sent_word_reg)
      |=> notify_wr_req && notify_wr_data == $past(cur_word))
    else $error("status change not written");

  // an event during a write of a word without it survives the ack
  a_merge_keep: assert property (
    (notify_wr_req && !wr_data_reg[TSN_BIT_SCR] && screen_switched && run_reg)
      |=> scr_pend_reg [*2])
    else $error("strobe lost while a write was in flight");

  // a finished write leaves its event bit set, even against a clear
  a_done_event: assert property (
    done_wr |=> irq_stat_reg[TSN_IRQ_DONE])
    else $error("write done event not recorded");

  c_write_done: cover property (done_wr);
  c_scr_notify: cover property (done_wr && wr_data_reg[TSN_BIT_SCR]);
  c_merged: cover property (notify_wr_req && screen_switched ##1 numeral_entered);
  c_stop_write: cover property (done_wr && !wr_data_reg[TSN_BIT_RUN]);

endmodule
`default_nettype wire

// ### dv/tsn_ctrl_mem.sv
// controller memory model holding the allocated status notify word
`timescale 1ns/100ps
`default_nettype none
module tsn_ctrl_mem
  import tsn_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic notify_wr_req,
  input wire logic [15:0] notify_wr_data,
  input wire logic [3:0] lat,
  input wire logic clr_run,
  output logic notify_wr_ack,
  output logic [15:0] mem_word,
  output int wr_cnt
);
  int wait_cnt;

  // ack comes lat plus one cycles after the request rises; lat zero answers in the next cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      notify_wr_ack <= 1'b0;
      wait_cnt <= 0;
    end
    else if (notify_wr_req && !notify_wr_ack && wait_cnt >= int'(lat))
    begin
      notify_wr_ack <= 1'b1;
      wait_cnt <= 0;
    end
    else
    begin
      notify_wr_ack <= 1'b0;
      wait_cnt <= notify_wr_req && !notify_wr_ack ? wait_cnt + 1 : 0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      mem_word <= 16'h0000;
      wr_cnt <= 0;
    end
    else if (notify_wr_req && notify_wr_ack)
    begin
      mem_word <= notify_wr_data;
      wr_cnt <= wr_cnt + 1;
    end
    else if (clr_run)
      mem_word[TSN_BIT_RUN] <= 1'b0;
  end
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the status notify block
`timescale 1ns/100ps
`default_nettype none
module tb
  import tsn_pkg::*;
;
  localparam int RC = 20;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic run_mode = 1'b0;
  logic sys_menu_shown = 1'b0;
  logic screen_switched = 1'b0;
  logic numeral_entered = 1'b0;
  logic notify_wr_req;
  logic [15:0] notify_wr_data;
  logic notify_wr_ack;
  logic irq;
  logic [3:0] lat = 4'h0;
  logic clr_run = 1'b0;
  logic [15:0] mem_word;
  int wr_cnt;
  int err_total = 0;
  int checks = 0;
  logic [31:0] rd;
  logic [15:0] wq[$];

  always #50 clk_sys = ~clk_sys;

  tsn_status_notify #(.REFRESH_CYCLES(RC)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_mode(run_mode), .sys_menu_shown(sys_menu_shown),
    .screen_switched(screen_switched), .numeral_entered(numeral_entered),
    .notify_wr_req(notify_wr_req), .notify_wr_data(notify_wr_data),
    .notify_wr_ack(notify_wr_ack), .irq(irq));

  tsn_ctrl_mem i_mem (.clk_sys(clk_sys), .rst_b(rst_b), .notify_wr_req(notify_wr_req),
    .notify_wr_data(notify_wr_data), .lat(lat), .clr_run(clr_run),
    .notify_wr_ack(notify_wr_ack), .mem_word(mem_word), .wr_cnt(wr_cnt));

  // log every completed word write
  always @(posedge clk_sys)
    if (notify_wr_req === 1'b1 && notify_wr_ack === 1'b1)
      wq.push_back(notify_wr_data);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic pulse(input logic [1:0] s);
    screen_switched <= s[0];
    numeral_entered <= s[1];
    @(posedge clk_sys);
    screen_switched <= 1'b0;
    numeral_entered <= 1'b0;
    repeat (60) @(posedge clk_sys);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog sized well above the expected run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    results();
  end

  initial
  begin
    logic [3:0] offs[5];
    logic [31:0] rv[5];
    logic [1:0] sel;
    logic [15:0] exp;
    logic hit;
    int n;
    offs = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    rv = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
    void'($urandom(32'h4ddf));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    // reset values, unmapped place reads zero
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, offs[i], 32'h0);
      chk(rd, rv[i]);
    end
    // writes held off while disabled
    bus(1'b1, TSN_OFF_CTRL, 32'h0);
    bus(1'b0, TSN_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    run_mode <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk(32'(wr_cnt), 32'h0);
    bus(1'b1, TSN_OFF_CTRL, 32'h1);
    repeat (60) @(posedge clk_sys);
    chk(32'(mem_word), 32'h8000);
    // random events and memory latency
    repeat (6)
    begin
      sel = 2'($urandom_range(3, 1));
      lat <= 4'($urandom_range(5, 0));
      wq.delete();
      pulse(sel);
      exp = 16'h8000 | (16'(sel[0]) << TSN_BIT_SCR) | (16'(sel[1]) << TSN_BIT_NUM);
      hit = 1'b0;
      foreach (wq[i])
        if (wq[i] === exp)
          hit = 1'b1;
      chk(32'(hit), 32'h1);
      chk(32'(wq[$]), 32'h8000);
      bus(1'b0, TSN_OFF_IRQ_STAT, 32'h0);
      chk(rd & 32'h3, 32'(sel));
      bus(1'b1, TSN_OFF_IRQ_STAT, 32'hF);
    end
    // interrupt raised, cleared, then masked
    bus(1'b1, TSN_OFF_IRQ_MASK, 32'h1);
    @(posedge clk_sys iff notify_wr_req === 1'b1);
    pulse(2'b01);
    chk(32'(irq), 32'h1);
    bus(1'b1, TSN_OFF_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h0);
    pulse(2'b10);
    chk(32'(irq), 32'h0);
    // host clears run bit, refresh must restore it
    clr_run <= 1'b1;
    @(posedge clk_sys);
    clr_run <= 1'b0;
    repeat (3 * RC) @(posedge clk_sys);
    chk(32'(mem_word), 32'h8000);
    // system menu drops the run bit in one last write, then stops all accesses
    sys_menu_shown <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk(32'(mem_word), 32'h0);
    bus(1'b0, TSN_OFF_IRQ_STAT, 32'h0);
    chk(rd & 32'h8, 32'h8);
    n = wr_cnt;
    pulse(2'b11);
    chk(32'(wr_cnt), 32'(n));
    chk(32'(notify_wr_req), 32'h0);
    results();
  end
endmodule
`default_nettype wire
